/* File: hcr_params.svh */
`ifndef HCR_PARAMS_SVH
`define HCR_PARAMS_SVH

// Register offsets (byte-wide register space)
`define HCR_OFF_STATUS_COMMAND 8'h00
`define HCR_OFF_VENDOR_LOW 8'h01
`define HCR_OFF_VENDOR_HIGH 8'h02
`define HCR_OFF_PRODUCT_LOW 8'h03
`define HCR_OFF_PRODUCT_HIGH 8'h04
`define HCR_OFF_RELEASE_LOW 8'h05
`define HCR_OFF_RELEASE_HIGH 8'h06
`define HCR_OFF_CONFIG_FIRST 8'h07
// Upper end of the protected range
`define HCR_OFF_PROTECT_LAST 8'h10

// Status/command field positions
`define HCR_BIT_ATTACH 0
`define HCR_BIT_LOCK 1
`define HCR_BIT_SOFT_RESET 2

// Configuration byte one field positions
`define HCR_BIT_POWER_SOURCE 7
`define HCR_BIT_LED_PRESENT 6
`define HCR_BIT_FULL_SPEED 5
`define HCR_BIT_PER_PORT_TT 4
`define HCR_BIT_EOP_SUPPRESS 3
`define HCR_BIT_OC_HI 2
`define HCR_BIT_OC_LO 1
`define HCR_BIT_POWER_SWITCH 0

// Reset values
`define HCR_RST_BYTE 8'h00

`endif

/* File: hcr_pkg.sv */
package hcr_pkg;

    // One byte access from the serial slave engine
    typedef struct packed {
        logic wr_stb;
        logic rd_stb;
        logic [7:0] addr;
        logic [7:0] wdata;
    } hcr_req_t;

    // Decoded configuration byte one plus resolved power mode
    typedef struct packed {
        logic self_powered;
        logic led_indicator_present;
        logic full_speed_only;
        logic per_port_translator;
        logic end_packet_suppress;
        logic [1:0] overcurrent_sense_mode;
        logic power_switch_mode;
    } hcr_cfg_t;

    // Overcurrent sense encodings
    typedef enum logic [1:0] {
        HCR_OC_GANGED = 2'h0,
        HCR_OC_PER_PORT = 2'h1,
        HCR_OC_NONE = 2'h2
    } hcr_oc_t;

    // Bank life cycle
    typedef enum logic [2:0] {
        HCR_ST_CONFIG = 3'b001,
        HCR_ST_ATTACH_ACK = 3'b010,
        HCR_ST_ATTACHED = 3'b100
    } hcr_state_t;

endpackage

/* File: hcr_bank.sv */
`timescale 1ns/1ps
`include "hcr_params.svh"

// How it works
// - Soft reset restores defaults, self clears.
// - Lock and attach set once, pin clears.
// - Attach signals upstream, interface powers down.
// - Six identifier bytes from address 01h.
// - Bit 7 power source, dynamic uses pin.
// - Bit 6 reports LED indicators present.
// - Bit 5 forces full speed only.
// - Bit 4 selects per-port translators.
// - Bit 3 suppresses EOF1 end of packet.
// - Bits 2:1 pick overcurrent sensing mode.
// - Bit 0 selects per-port power switching.
// - Byte-wide access, 8-bit address, one byte.
// - Dynamic enable lets pin set power mode.
module hcr_bank (
    input wire logic clk, // 20 MHz system clock
    input wire logic nrst, // Asynchronous active-low pin reset
    input wire hcr_pkg::hcr_req_t req, // Byte access from serial engine
    input wire logic ack_done, // Acknowledge of current write finished
    input wire logic dynamic_power_en, // Dynamic power switching enable
    input wire logic local_power_present_pin, // Self-power pin, asynchronous
    output logic [7:0] rdata, // Read data of last read
    output logic rvalid, // Read data valid, one cycle
    output logic soft_reset_busy, // Soft reset in progress
    output logic attach_request, // Signal attach upstream
    output logic serial_power_down, // Serial slave interface off
    output logic config_locked, // Lock bit state
    output logic [15:0] vendor_ident, // Vendor identifier
    output logic [15:0] product_ident, // Product identifier
    output logic [15:0] release_ident, // Release identifier
    output hcr_pkg::hcr_cfg_t cfg // Decoded configuration
);
    import hcr_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Storage
    logic [7:0] ident_ff [0:5]; // Identifier bytes 01h..06h
    logic [7:0] cfg1_ff; // Configuration byte one
    logic lock_ff; // Write protect lock
    logic attach_ff; // Attach request
    logic srst_ff; // Soft reset pulse bit
    hcr_state_t state_ff; // Life cycle state
    logic [1:0] pin_sync_ff; // Self-power pin synchroniser
    logic [7:0] nxt_rdata; // Next read data

    // Writes are accepted only while the serial interface is alive
    logic wr_ok;
    logic in_protect;
    assign wr_ok = req.wr_stb && (state_ff == HCR_ST_CONFIG) && !srst_ff;
    // Lock only guards the identifier and configuration range; status stays writable
    assign in_protect = (req.addr >= `HCR_OFF_VENDOR_LOW) && (req.addr <= `HCR_OFF_PROTECT_LAST);

    ////////////////////////////////////////////////////////////////////////////////
    // Soft reset: one cycle pulse, clears itself while applying defaults
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            srst_ff <= 1'b0;
        else if (srst_ff)
            srst_ff <= 1'b0;
        else if (wr_ok && req.addr == `HCR_OFF_STATUS_COMMAND)
            srst_ff <= req.wdata[`HCR_BIT_SOFT_RESET];
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Write-once lock and attach; only the pin clears them, so soft reset spares them
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            lock_ff <= 1'b0;
            attach_ff <= 1'b0;
        end
        else if (wr_ok && req.addr == `HCR_OFF_STATUS_COMMAND)
        begin
            // Ones set, zeros never clear
            lock_ff <= lock_ff | req.wdata[`HCR_BIT_LOCK];
            attach_ff <= attach_ff | req.wdata[`HCR_BIT_ATTACH];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Identifier bytes, one generate entry per byte
    genvar gi;
    generate
        for (gi = 0; gi < 6; gi++)
        begin : g_ident
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                    ident_ff[gi] <= `HCR_RST_BYTE;
                else if (srst_ff)
                    ident_ff[gi] <= `HCR_RST_BYTE;
                else if (wr_ok && !(lock_ff && in_protect) && req.addr == (`HCR_OFF_VENDOR_LOW + 8'(gi)))
                    ident_ff[gi] <= req.wdata;
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Configuration byte one
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            cfg1_ff <= `HCR_RST_BYTE;
        else if (srst_ff)
            cfg1_ff <= `HCR_RST_BYTE;
        else if (wr_ok && !(lock_ff && in_protect) && req.addr == `HCR_OFF_CONFIG_FIRST)
            cfg1_ff <= req.wdata;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Life cycle: power down only after the attach write's acknowledge
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            state_ff <= HCR_ST_CONFIG;
        else
        begin
            case (state_ff)
                HCR_ST_CONFIG:
                    if (wr_ok && req.addr == `HCR_OFF_STATUS_COMMAND && req.wdata[`HCR_BIT_ATTACH])
                        state_ff <= HCR_ST_ATTACH_ACK;
                HCR_ST_ATTACH_ACK:
                    if (ack_done)
                        state_ff <= HCR_ST_ATTACHED;
                HCR_ST_ATTACHED:
                    state_ff <= HCR_ST_ATTACHED;
                default:
                    state_ff <= HCR_ST_CONFIG;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Self-power pin is asynchronous: two flops before use
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            pin_sync_ff <= 2'h0;
        else
            pin_sync_ff <= {pin_sync_ff[0], local_power_present_pin};
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read mux; reads still return contents while locked
    always_comb
    begin
        nxt_rdata = 8'h00;
        case (req.addr)
            `HCR_OFF_STATUS_COMMAND: nxt_rdata = {5'h00, srst_ff, lock_ff, attach_ff};
            `HCR_OFF_CONFIG_FIRST: nxt_rdata = cfg1_ff;
            default:
                if (req.addr >= `HCR_OFF_VENDOR_LOW && req.addr <= `HCR_OFF_RELEASE_HIGH)
                    nxt_rdata = ident_ff[3'(req.addr - `HCR_OFF_VENDOR_LOW)];
        endcase
    end

    // Read data registered; unmapped addresses read zero
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= 8'h00;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd_stb && (state_ff == HCR_ST_CONFIG);
            if (req.rd_stb)
                rdata <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign soft_reset_busy = srst_ff;
    assign attach_request = attach_ff;
    assign serial_power_down = (state_ff == HCR_ST_ATTACHED);
    assign config_locked = lock_ff;
    assign vendor_ident = {ident_ff[1], ident_ff[0]};
    assign product_ident = {ident_ff[3], ident_ff[2]};
    assign release_ident = {ident_ff[5], ident_ff[4]};
    // Dynamic switching hands the power decision to the pin
    assign cfg.self_powered = dynamic_power_en ? pin_sync_ff[1] : cfg1_ff[`HCR_BIT_POWER_SOURCE];
    assign cfg.led_indicator_present = cfg1_ff[`HCR_BIT_LED_PRESENT];
    assign cfg.full_speed_only = cfg1_ff[`HCR_BIT_FULL_SPEED];
    assign cfg.per_port_translator = cfg1_ff[`HCR_BIT_PER_PORT_TT];
    assign cfg.end_packet_suppress = cfg1_ff[`HCR_BIT_EOP_SUPPRESS];
    // Value 1x means no sensing; legality against bus power is left to the host
    assign cfg.overcurrent_sense_mode = cfg1_ff[`HCR_BIT_OC_HI:`HCR_BIT_OC_LO];
    assign cfg.power_switch_mode = cfg1_ff[`HCR_BIT_POWER_SWITCH];

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    a_lock_sticky: assert property (@(posedge clk) disable iff (!nrst)
        lock_ff |=> lock_ff) else $error("lock bit cleared without pin reset");
    a_attach_sticky: assert property (@(posedge clk) disable iff (!nrst)
        attach_ff |=> attach_ff) else $error("attach bit cleared without pin reset");
    a_srst_self_clear: assert property (@(posedge clk) disable iff (!nrst)
        srst_ff |=> !srst_ff && cfg1_ff == 8'h00 && vendor_ident == 16'h0000) else $error("soft reset not applied");
    a_locked_hold: assert property (@(posedge clk) disable iff (!nrst)
        lock_ff && !srst_ff |=> $stable(cfg1_ff) && $stable(vendor_ident)) else $error("locked storage changed");
    a_cfg_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_ok && !lock_ff && req.addr == 8'h07 |=> cfg1_ff == $past(req.wdata)) else $error("config write lost");
    a_ident_write: assert property (@(posedge clk) disable iff (!nrst)
        wr_ok && !lock_ff && req.addr == 8'h01 |=> vendor_ident[7:0] == $past(req.wdata))
        else $error("identifier write lost");
    a_power_down: assert property (@(posedge clk) disable iff (!nrst)
        state_ff == HCR_ST_ATTACH_ACK && ack_done |=> serial_power_down && attach_request) else $error("no power down");
    a_no_early_down: assert property (@(posedge clk) disable iff (!nrst)
        serial_power_down |-> attach_ff) else $error("power down without attach");
    a_power_pick: assert property (@(posedge clk) disable iff (!nrst)
        !dynamic_power_en |-> cfg.self_powered == cfg1_ff[7]) else $error("power source mismatch");
    a_status_read: assert property (@(posedge clk) disable iff (!nrst)
        req.rd_stb && req.addr == 8'h00 && state_ff == HCR_ST_CONFIG |=> rvalid && rdata[7:3] == 5'h00)
        else $error("status read wrong");
endmodule

/* File: hcr_host_model.sv */
`timescale 1ns/1ps

// Host side of the byte access port; changes its lines on the falling edge
module hcr_host_model (
    input wire logic clk, // System clock
    input wire logic [7:0] rdata, // Read data from the bank
    input wire logic rvalid, // Read data valid pulse
    output hcr_pkg::hcr_req_t req, // Byte access toward the bank
    output logic ack_done // Attach write acknowledged
);
    import hcr_pkg::*;

    // Idle lines
    initial
    begin
        req = '{wr_stb: 1'b0, rd_stb: 1'b0, addr: 8'hff, wdata: 8'hff};
        ack_done = 1'b0;
    end

    // One write byte; reserved command bits are never sent as one
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.wr_stb = 1'b1;
        req.addr = a;
        req.wdata = (a == 8'h00) ? (d & 8'h07) : d;
        @(negedge clk);
        req.wr_stb = 1'b0;
        // Released lines flip so a stale value never looks fresh
        req.addr = ~req.addr;
        req.wdata = ~req.wdata;
    endtask

    // One read byte; answer is looked at one cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic v, output logic [7:0] d);
        @(negedge clk);
        req.rd_stb = 1'b1;
        req.addr = a;
        @(negedge clk);
        req.rd_stb = 1'b0;
        req.addr = ~req.addr;
        v = rvalid;
        d = rdata;
    endtask

    // Acknowledge of the attach write completes
    task automatic ack();
        @(negedge clk);
        ack_done = 1'b1;
        @(negedge clk);
        ack_done = 1'b0;
    endtask
endmodule

/* File: tb.sv */
`timescale 1ns/1ps

module tb;
    import hcr_pkg::*;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } hcr_row_t;

    logic clk = 1'b0; // 50 ns period
    logic nrst = 1'b0; // Pin reset
    logic dyn = 1'b0; // Dynamic power enable
    logic pin = 1'b1; // Local power pin
    hcr_req_t req; // Host request
    logic ack_done; // Attach acknowledge
    logic [7:0] rdata; // Read data
    logic rvalid, busy, attach, pdown, locked; // Status outputs
    logic [15:0] vid, pid, rid; // Identifiers
    hcr_cfg_t cfg; // Decoded configuration
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    logic v; // Captured read valid
    logic [7:0] d; // Captured read data
    // Write, then read back; the last address is unmapped
    hcr_row_t rows [8] = '{'{8'h01, 8'ha5, 8'ha5}, '{8'h02, 8'h5a, 8'h5a}, '{8'h03, 8'hc3, 8'hc3},
        '{8'h04, 8'h3c, 8'h3c}, '{8'h05, 8'h81, 8'h81}, '{8'h06, 8'h18, 8'h18},
        '{8'h07, 8'hb5, 8'hb5}, '{8'h20, 8'hff, 8'h00}};

    always #25 clk = ~clk;

    hcr_bank DUT (.clk(clk), .nrst(nrst), .req(req), .ack_done(ack_done), .dynamic_power_en(dyn),
        .local_power_present_pin(pin), .rdata(rdata), .rvalid(rvalid), .soft_reset_busy(busy),
        .attach_request(attach), .serial_power_down(pdown), .config_locked(locked),
        .vendor_ident(vid), .product_ident(pid), .release_ident(rid), .cfg(cfg));

    hcr_host_model host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .req(req), .ack_done(ack_done));

    ////////////////////////////////////////////////////////////////////////////
    task automatic print_verdict();
        if (err_count == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Plain value compare
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // Read answer compare; a refused read must show no valid
    task automatic chk_rd(input logic [7:0] a, input logic [8:0] exp);
        host.rd(a, v, d);
        chk({7'h00, v, v ? d : 8'h00}, {7'h00, exp});
    endtask

    // Hang guard, far above the 89 cycles needed
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            err_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (6) @(negedge clk);
        nrst = 1'b1;
        foreach (rows[i])
        begin
            host.wr(rows[i].addr, rows[i].wdata);
            chk_rd(rows[i].addr, {1'b1, rows[i].exp});
        end
        chk(vid, 16'h5aa5);
        chk(pid, 16'h3cc3);
        chk(rid, 16'h1881);
        chk(cfg, 16'h00b5);
        // Every sense code, high bit pattern 1x included
        for (int m = 0; m < 4; m++)
        begin
            host.wr(8'h07, 8'(m << 1));
            chk(cfg.overcurrent_sense_mode, m[1:0]);
        end
        // Dynamic mode: pin wins over the stored zero
        @(negedge clk);
        dyn = 1'b1;
        repeat (4) @(negedge clk);
        chk(cfg.self_powered, 1'b1);
        pin = 1'b0;
        repeat (4) @(negedge clk);
        chk(cfg.self_powered, 1'b0);
        dyn = 1'b0;
        // Soft reset returns storage to defaults
        host.wr(8'h00, 8'h04);
        chk(busy, 1'b1);
        repeat (2) @(negedge clk);
        chk(busy, 1'b0);
        chk(vid, 16'h0000);
        chk_rd(8'h00, 9'h100);
        // Lock only after loading
        host.wr(8'h01, 8'h77);
        host.wr(8'h00, 8'h02);
        chk(locked, 1'b1);
        host.wr(8'h01, 8'h11);
        chk_rd(8'h01, 9'h177);
        host.wr(8'h00, 8'h00);
        host.wr(8'h00, 8'h04);
        repeat (2) @(negedge clk);
        chk(locked, 1'b1);
        chk_rd(8'h01, 9'h100);
        // Attach, then the serial side goes quiet after the acknowledge
        host.wr(8'h00, 8'h01);
        chk(attach, 1'b1);
        chk(pdown, 1'b0);
        host.ack();
        @(negedge clk);
        chk(pdown, 1'b1);
        chk_rd(8'h07, 9'h000);
        // Only the pin clears the write-once bits
        nrst = 1'b0;
        @(negedge clk);
        chk({attach, locked, pdown}, 16'h0000);
        nrst = 1'b1;
        chk_rd(8'h00, 9'h100);
        chk_rd(8'h07, 9'h100);
        print_verdict();
    end
endmodule
